// >>> include/rdf_regs.svh
// constants of the receive decimation chain
`ifndef RDF_REGS_SVH
`define RDF_REGS_SVH
`define RDF_ADC_W 12
`define RDF_SMP_W 14
`define RDF_ACC_W 48
`define RDF_MAX_TAPS 17
`define RDF_FIR_DEPTH 128
`define RDF_FIR_AW 7
`define RDF_FIR_LANES 16
`define RDF_FIR_LANE_W 4
`define RDF_COEF_W 16
`define RDF_OUT_MAX 2047
`define RDF_OUT_MIN -2048
`define RDF_CFG_BYPASS 2'h0
`define RDF_CFG_DEC2 2'h1
`define RDF_CFG_THIRD_RATE_STAGE 2'h2
`define RDF_FIR_DEC1 2'h0
`define RDF_FIR_DEC2 2'h1
`define RDF_FIR_DEC4 2'h2
`define RDF_FIR_BYPASS 2'h3
`define RDF_GAIN_M12 2'h0
`define RDF_GAIN_M6 2'h1
`define RDF_GAIN_0 2'h2
`define RDF_GAIN_P6 2'h3
`define RDF_FIR_SH_MAX 16
`define RDF_SH_FIRST_HB 4
`define RDF_SH_FIRST_THIRD_RATE_STAGE 14
`define RDF_SH_SECOND 8
`define RDF_SH_THIRD 11
`define RDF_FAC_1 3'h1
`define RDF_FAC_2 3'h2
`define RDF_FAC_3 3'h3
`define RDF_FAC_4 3'h4
`define RDF_BUF_DEPTH 2'h2
`endif

// >>> include/rdf_pkg.sv
// types and saturation helpers of the receive decimation chain
`include "rdf_regs.svh"
package rdf_pkg;
  typedef logic signed [`RDF_SMP_W-1:0] rdf_smp_t;
  typedef logic signed [`RDF_ACC_W-1:0] rdf_acc_t;
  typedef rdf_smp_t [`RDF_MAX_TAPS-1:0] rdf_win_t;
  typedef struct packed {
    logic vld;
    rdf_smp_t i;
    rdf_smp_t q;
  } rdf_pair_s;
  typedef struct packed {
    logic signed [`RDF_ADC_W-1:0] i;
    logic signed [`RDF_ADC_W-1:0] q;
  } rdf_iq12_s;
  typedef enum logic [1:0] {
    RDF_FIR_IDLE = 2'b01,
    RDF_FIR_MAC = 2'b10
  } rdf_fir_st_e;
  // true when a value falls outside the 12-bit output range
  function automatic logic rdf_ovr(input rdf_acc_t v);
    return (v > rdf_acc_t'(`RDF_OUT_MAX)) || (v < rdf_acc_t'(`RDF_OUT_MIN));
  endfunction
  // clamp a value to the 12-bit output range
  function automatic rdf_smp_t rdf_clamp(input rdf_acc_t v);
    if (v > rdf_acc_t'(`RDF_OUT_MAX))
      return rdf_smp_t'(`RDF_OUT_MAX);
    else if (v < rdf_acc_t'(`RDF_OUT_MIN))
      return rdf_smp_t'(`RDF_OUT_MIN);
    else
      return rdf_smp_t'(v);
  endfunction
endpackage

// >>> design/rdf_rx_chain.sv
// receive decimation chain: three fixed stages, programmable fir, output buffer
`timescale 1ns/10ps
`include "rdf_regs.svh"

// one fixed-coefficient decimating stage, I and Q together
module rdf_fixed_stage #(parameter int STAGE = 0) (
  input wire logic core_clk, // adc sample clock
  input wire logic rst_b, // async reset, active low
  input wire logic hold, // freeze while output buffer is full
  input wire logic [1:0] mode, // bypass, by two, by three on the first stage only
  input rdf_pkg::rdf_pair_s in_pair, // incoming sample pair
  output rdf_pkg::rdf_pair_s out_r // decimated sample pair
);
  import rdf_pkg::*;
  localparam int FIRST_HB [0:16] = '{1, 4, 6, 4, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  localparam int FIRST_THIRD_RATE_STAGE [0:16] = '{55, 83, 0, -393, -580, 0, 1914, 4041, 5120,
    4041, 1914, 0, -580, -393, 0, 83, 55};
  localparam int SECOND [0:16] = '{-9, 0, 73, 128, 73, 0, -9, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  localparam int THIRD [0:16] = '{-8, 0, 42, 0, -147, 0, 619, 1013, 619, 0, -147, 0, 42, 0, -8, 0, 0};

  rdf_win_t win_i_r; // past samples, newest at index 0
  rdf_win_t win_q_r; // past samples, newest at index 0
  rdf_win_t cur_i; // window including the arriving sample
  rdf_win_t cur_q; // window including the arriving sample
  logic [2:0] ph_r; // input phase within one decimation period
  logic [2:0] fac; // decimation factor
  logic take; // sample accepted this cycle
  logic emit; // this input completes an output period

  // tap lookup for this stage and mode
  function automatic int tap(input logic [1:0] md, input int k);
    if (STAGE == 0)
      return (md == `RDF_CFG_THIRD_RATE_STAGE) ? FIRST_THIRD_RATE_STAGE[k] : FIRST_HB[k];
    else if (STAGE == 1)
      return SECOND[k];
    else
      return THIRD[k];
  endfunction

  // full-precision convolution then normalising shift
  function automatic rdf_smp_t filt(input rdf_win_t w, input logic [1:0] md);
    rdf_acc_t acc;
    int sh;
    acc = '0;
    for (int k = 0; k < `RDF_MAX_TAPS; k++)
      acc = acc + rdf_acc_t'(tap(md, k)) * rdf_acc_t'(w[k]);
    if (STAGE == 0)
      sh = (md == `RDF_CFG_THIRD_RATE_STAGE) ? `RDF_SH_FIRST_THIRD_RATE_STAGE : `RDF_SH_FIRST_HB;
    else if (STAGE == 1)
      sh = `RDF_SH_SECOND;
    else
      sh = `RDF_SH_THIRD;
    // 14-bit result has headroom for every fixed set, so no wrap is possible
    return rdf_smp_t'(acc >>> sh);
  endfunction

  // window assembly and period bookkeeping
  always_comb
  begin
    cur_i = {win_i_r[`RDF_MAX_TAPS-2:0], in_pair.i};
    cur_q = {win_q_r[`RDF_MAX_TAPS-2:0], in_pair.q};
    fac = (STAGE == 0 && mode == `RDF_CFG_THIRD_RATE_STAGE) ? `RDF_FAC_3 : `RDF_FAC_2;
    take = in_pair.vld && !hold;
    emit = take && (ph_r == fac - `RDF_FAC_1);
  end

  // delay line runs at the input data rate
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      win_i_r <= '0;
      win_q_r <= '0;
    end
    else if (take)
    begin
      win_i_r <= cur_i;
      win_q_r <= cur_q;
    end
  end

  // phase counter picks which filtered sample survives
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      ph_r <= '0;
    else if (mode == `RDF_CFG_BYPASS)
      ph_r <= '0;
    else if (emit)
      ph_r <= '0;
    else if (take)
      ph_r <= ph_r + `RDF_FAC_1;
  end

  // registered output: filtered value kept only on the last phase
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      out_r <= '0;
    else if (!hold)
    begin
      if (mode == `RDF_CFG_BYPASS)
        out_r <= in_pair;
      else
      begin
        out_r.vld <= emit;
        if (emit)
        begin
          out_r.i <= filt(cur_i, mode);
          out_r.q <= filt(cur_q, mode);
        end
      end
    end
  end
endmodule

// programmable polyphase fir, sixteen taps per fir clock
module rdf_prog_fir (
  input wire logic core_clk, // adc sample clock
  input wire logic rst_b, // async reset, active low
  input wire logic hold, // freeze while output buffer is full
  input wire logic [1:0] mode, // dec 1, 2, 4 or bypass
  input wire logic [1:0] gain, // -12, -6, 0, +6 dB
  input wire logic [2:0] taps_sel, // taps = 16 * (taps_sel + 1)
  input wire logic clk_div2, // fir clock is half the adc clock
  input wire logic [`RDF_FIR_AW-1:0] coef_addr, // coefficient index
  input wire logic [7:0] coef_byte, // coefficient byte
  input wire logic coef_wr_lo, // write low byte to staging
  input wire logic coef_wr_hi, // write high byte and commit
  input rdf_pkg::rdf_pair_s in_pair, // incoming sample pair
  output rdf_pkg::rdf_pair_s out_r, // output pair, clamped except in bypass
  output logic ovf_r // one-cycle overrange pulse
);
  import rdf_pkg::*;
  logic signed [`RDF_COEF_W-1:0] coef_mem [0:`RDF_FIR_DEPTH-1]; // tap memory
  rdf_smp_t hist_i [0:`RDF_FIR_DEPTH-1]; // I sample history
  rdf_smp_t hist_q [0:`RDF_FIR_DEPTH-1]; // Q sample history
  logic [7:0] lo_stage_r; // low byte awaiting its high byte
  logic [`RDF_FIR_AW-1:0] wptr_r; // next history slot
  logic [`RDF_FIR_AW-1:0] base_r; // newest sample of the current output
  logic [2:0] pass_r; // group of sixteen taps being summed
  logic [2:0] dph_r; // input phase within one decimation period
  logic tick_r; // half-rate fir clock phase
  rdf_fir_st_e st_r; // mac sequencer state
  rdf_acc_t acc_i_r; // running I sum
  rdf_acc_t acc_q_r; // running Q sum
  rdf_acc_t acc_i_nxt; // I sum after this pass
  rdf_acc_t acc_q_nxt; // Q sum after this pass
  rdf_acc_t res_i; // I after gain shift
  rdf_acc_t res_q; // Q after gain shift
  logic [2:0] fac; // decimation factor
  logic fir_tick; // one fir clock period elapsed
  logic take; // sample accepted this cycle
  logic start; // a new output is due
  logic last; // final pass of this output
  int sh; // total normalising shift

  // decimation factor, fir clock and pass bookkeeping
  always_comb
  begin
    case (mode)
      `RDF_FIR_DEC2: fac = `RDF_FAC_2;
      `RDF_FIR_DEC4: fac = `RDF_FAC_4;
      default: fac = `RDF_FAC_1;
    endcase
    fir_tick = !clk_div2 || tick_r;
    take = in_pair.vld && !hold && (mode != `RDF_FIR_BYPASS);
    start = take && (dph_r == fac - `RDF_FAC_1);
    last = (pass_r == taps_sel);
    // coefficients are 1.15; +6 dB built in, gain code moves the shift
    sh = `RDF_FIR_SH_MAX - int'(gain);
  end

  // sixteen multiply-accumulates per fir clock, history read backwards from base
  always_comb
  begin
    acc_i_nxt = acc_i_r;
    acc_q_nxt = acc_q_r;
    for (int l = 0; l < `RDF_FIR_LANES; l++)
    begin
      logic [`RDF_FIR_AW-1:0] ci;
      logic [`RDF_FIR_AW-1:0] hi;
      // oldest group first, so inputs arriving during the sum cannot overwrite its taps
      ci = {taps_sel - pass_r, l[`RDF_FIR_LANE_W-1:0]};
      hi = base_r - ci;
      acc_i_nxt = acc_i_nxt + rdf_acc_t'(coef_mem[ci]) * rdf_acc_t'(hist_i[hi]);
      acc_q_nxt = acc_q_nxt + rdf_acc_t'(coef_mem[ci]) * rdf_acc_t'(hist_q[hi]);
    end
    res_i = acc_i_nxt >>> sh;
    res_q = acc_q_nxt >>> sh;
  end

  // coefficient load: low byte staged, high byte commits the 16-bit word
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      lo_stage_r <= '0;
    else if (coef_wr_lo)
      lo_stage_r <= coef_byte;
  end

  // coefficient memory, no reset
  always_ff @(posedge core_clk)
  begin
    if (coef_wr_hi)
      coef_mem[coef_addr] <= {coef_byte, lo_stage_r};
  end

  // sample history, circular
  always_ff @(posedge core_clk)
  begin
    if (take)
    begin
      hist_i[wptr_r] <= in_pair.i;
      hist_q[wptr_r] <= in_pair.q;
    end
  end

  // write pointer, decimation phase and half-rate tick
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wptr_r <= '0;
      dph_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= !tick_r;
      if (take)
      begin
        wptr_r <= wptr_r + 7'h1;
        dph_r <= start ? 3'h0 : dph_r + `RDF_FAC_1;
      end
      else if (mode == `RDF_FIR_BYPASS)
        dph_r <= '0;
    end
  end

  // mac sequencer; a new start restarts the sum if the ratio limit was broken
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= RDF_FIR_IDLE;
      base_r <= '0;
      pass_r <= '0;
      acc_i_r <= '0;
      acc_q_r <= '0;
    end
    else if (start)
    begin
      st_r <= RDF_FIR_MAC;
      base_r <= wptr_r; // newest sample just written
      pass_r <= '0;
      acc_i_r <= '0;
      acc_q_r <= '0;
    end
    else if (!hold)
    begin
      case (st_r)
        RDF_FIR_MAC:
        begin
          if (fir_tick)
          begin
            acc_i_r <= acc_i_nxt;
            acc_q_r <= acc_q_nxt;
            pass_r <= pass_r + 3'h1;
            if (last)
              st_r <= RDF_FIR_IDLE;
          end
        end
        default: st_r <= RDF_FIR_IDLE;
      endcase
    end
  end

  // output: clamp on overrange, pulse the flag
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_r <= '0;
      ovf_r <= 1'b0;
    end
    else if (!hold)
    begin
      if (mode == `RDF_FIR_BYPASS)
      begin
        out_r <= in_pair;
        ovf_r <= 1'b0;
      end
      else
      begin
        out_r.vld <= 1'b0;
        ovf_r <= 1'b0;
        // a start on the final pass still lets this output out: ratio limit is exact
        if (st_r == RDF_FIR_MAC && fir_tick && last)
        begin
          out_r.vld <= 1'b1;
          out_r.i <= rdf_clamp(res_i);
          out_r.q <= rdf_clamp(res_q);
          ovf_r <= rdf_ovr(res_i) || rdf_ovr(res_q);
        end
      end
    end
    else
      ovf_r <= 1'b0;
  end
endmodule

// top: cascade, overflow status and two-entry output buffer
module rdf_rx_chain (
  input wire logic core_clk, // adc sample clock, 10 MHz
  input wire logic rst_b, // async reset, active low
  input wire logic adc_valid, // adc sample pair present
  input rdf_pkg::rdf_iq12_s adc_data, // adc I and Q samples
  output logic adc_ready, // chain accepts a sample
  input wire logic [1:0] first_mode, // first stage: bypass, by two, by three
  input wire logic second_en, // second half-band decimates
  input wire logic third_en, // third half-band decimates
  input wire logic [1:0] fir_mode, // fir dec 1, 2, 4 or bypass
  input wire logic [1:0] fir_gain, // fir gain select
  input wire logic [2:0] fir_taps_sel, // fir taps = 16 * (sel + 1)
  input wire logic fir_clk_div2, // fir clock at half rate
  input wire logic [6:0] coef_addr, // coefficient index
  input wire logic [7:0] coef_byte, // coefficient byte
  input wire logic coef_wr_lo, // low coefficient byte strobe
  input wire logic coef_wr_hi, // high coefficient byte strobe
  input wire logic ovf_clear, // clear overflow status
  output logic ovf_status_r, // sticky fir overflow status
  output logic ctrl_out_ovf, // fir overflow pulse on control pin
  output logic out_valid, // output pair ready
  input wire logic out_ready, // baseband takes the pair
  output rdf_pkg::rdf_iq12_s out_data // output I and Q
);
  import rdf_pkg::*;
  rdf_pair_s s0_in; // adc pair widened
  rdf_pair_s s1_out; // first stage output
  rdf_pair_s s2_out; // second stage output
  rdf_pair_s s3_out; // third stage output
  rdf_pair_s fir_out; // fir output
  rdf_iq12_s buf_r [0:1]; // two-entry output buffer
  logic [1:0] cnt_r; // buffer fill
  logic wp_r; // buffer write slot
  logic rp_r; // buffer read slot
  logic hold; // buffer full: freeze the chain
  logic push; // word enters buffer
  logic pop; // word leaves buffer
  logic fir_ovf; // fir overrange pulse
  rdf_smp_t cl_i; // I clamped to the output range
  rdf_smp_t cl_q; // Q clamped to the output range

  // back-pressure and input widening
  always_comb
  begin
    hold = (cnt_r == `RDF_BUF_DEPTH);
    adc_ready = !hold;
    s0_in.vld = adc_valid;
    s0_in.i = rdf_smp_t'(adc_data.i);
    s0_in.q = rdf_smp_t'(adc_data.q);
    out_valid = (cnt_r != 2'h0);
    push = fir_out.vld && !hold;
    pop = out_valid && out_ready;
    // bypassed fir hands over 14 bits; clamp before the 12-bit buffer
    cl_i = rdf_clamp(rdf_acc_t'(fir_out.i));
    cl_q = rdf_clamp(rdf_acc_t'(fir_out.q));
    out_data = buf_r[rp_r];
    ctrl_out_ovf = fir_ovf;
  end

  rdf_fixed_stage #(.STAGE(0)) u_first_halfband_stage (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .hold(hold),
    .mode(first_mode),
    .in_pair(s0_in),
    .out_r(s1_out)
  );

  rdf_fixed_stage #(.STAGE(1)) u_second_halfband_stage (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .hold(hold),
    .mode(second_en ? `RDF_CFG_DEC2 : `RDF_CFG_BYPASS),
    .in_pair(s1_out),
    .out_r(s2_out)
  );

  rdf_fixed_stage #(.STAGE(2)) u_third_halfband_stage (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .hold(hold),
    .mode(third_en ? `RDF_CFG_DEC2 : `RDF_CFG_BYPASS),
    .in_pair(s2_out),
    .out_r(s3_out)
  );

  rdf_prog_fir u_prog_fir (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .hold(hold),
    .mode(fir_mode),
    .gain(fir_gain),
    .taps_sel(fir_taps_sel),
    .clk_div2(fir_clk_div2),
    .coef_addr(coef_addr),
    .coef_byte(coef_byte),
    .coef_wr_lo(coef_wr_lo),
    .coef_wr_hi(coef_wr_hi),
    .in_pair(s3_out),
    .out_r(fir_out),
    .ovf_r(fir_ovf)
  );

  // sticky overflow status; a new event beats a clear
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      ovf_status_r <= 1'b0;
    else if (fir_ovf)
      ovf_status_r <= 1'b1;
    else if (ovf_clear)
      ovf_status_r <= 1'b0;
  end

  // buffer storage; bypassed fir is clamped silently to 12 bits
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      buf_r[0] <= '0;
      buf_r[1] <= '0;
    end
    else if (push)
    begin
      buf_r[wp_r].i <= cl_i[`RDF_ADC_W-1:0];
      buf_r[wp_r].q <= cl_q[`RDF_ADC_W-1:0];
    end
  end

  // buffer pointers and fill count
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r <= '0;
      wp_r <= 1'b0;
      rp_r <= 1'b0;
    end
    else
    begin
      if (push)
        wp_r <= !wp_r;
      if (pop)
        rp_r <= !rp_r;
      if (push && !pop)
        cnt_r <= cnt_r + 2'h1;
      else if (pop && !push)
        cnt_r <= cnt_r - 2'h1;
    end
  end
endmodule

// >>> testbench/rdf_rx_chain_chk.sv
// port-level assertion checker of the receive decimation chain
`timescale 1ns/10ps
`include "rdf_regs.svh"
module rdf_rx_chain_chk (
  input wire logic core_clk, // adc sample clock
  input wire logic rst_b, // async reset, active low
  input wire logic adc_valid, // adc pair offered
  input rdf_pkg::rdf_iq12_s adc_data, // adc pair
  input wire logic adc_ready, // chain accepts a pair
  input wire logic [1:0] first_mode, // first stage setting
  input wire logic second_en, // second half-band decimates
  input wire logic third_en, // third half-band decimates
  input wire logic [1:0] fir_mode, // fir setting
  input wire logic ovf_clear, // overflow status clear
  input wire logic ovf_status_r, // sticky overflow status
  input wire logic ctrl_out_ovf, // overflow pulse on control pin
  input wire logic out_valid, // output pair present
  input wire logic out_ready, // baseband takes the pair
  input rdf_pkg::rdf_iq12_s out_data // output pair
);
  import rdf_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  logic byp_all; // every stage bypassed
  assign byp_all = (first_mode == `RDF_CFG_BYPASS) && !second_en && !third_en && (fir_mode == `RDF_FIR_BYPASS);
  // receiver holds off an offered pair
  sequence stall_s;
    out_valid && !out_ready;
  endsequence
  // a pair enters an empty, fully bypassed chain while the receiver keeps taking
  sequence byp_take_s;
    byp_all && !out_valid && adc_valid && adc_ready && out_ready ##1 out_ready [*4];
  endsequence
  AST_BYP_LAT: assert property (byp_take_s |=> out_valid && out_data == $past(adc_data, 5))
    else $error("bypassed pair late or altered");
  AST_OUT_HOLD: assert property (stall_s |=> out_valid && $stable(out_data))
    else $error("offered pair dropped or changed while stalled");
  AST_READY_VALID: assert property (!adc_ready |-> out_valid)
    else $error("input refused with empty output");
  AST_READY_POP: assert property (!adc_ready |-> $past(out_ready) == 1'b0)
    else $error("input refused after a pop");
  AST_OVF_SET: assert property (ctrl_out_ovf |-> ##[0:1] ovf_status_r)
    else $error("overrange pulse not recorded in status");
  AST_OVF_HOLD: assert property (ovf_status_r && !ovf_clear |=> ovf_status_r)
    else $error("overflow status lost without clear");
  AST_OVF_ROSE: assert property ($rose(ovf_status_r) |-> ctrl_out_ovf || $past(ctrl_out_ovf))
    else $error("overflow status set without overrange pulse");
  AST_OVF_CLR: assert property (ovf_clear && !ctrl_out_ovf |=> !ovf_status_r || ctrl_out_ovf)
    else $error("overflow status not cleared");
  AST_BYP_NOFLAG: assert property ((fir_mode == `RDF_FIR_BYPASS) [*4] |-> !ctrl_out_ovf)
    else $error("overrange flagged with fir bypassed");
endmodule

// >>> testbench/rdf_bb_sink.sv
// baseband receiver model: takes output pairs and may stall
`timescale 1ns/10ps
module rdf_bb_sink (
  input wire logic core_clk, // sample clock
  input wire logic rst_b, // async reset, active low
  input wire logic stall_en, // ready only one cycle of four
  input wire logic out_valid, // pair offered
  input rdf_pkg::rdf_iq12_s out_data, // offered pair
  output logic out_ready, // pair taken at next edge
  output logic [15:0] got_cnt, // pairs taken since reset
  output rdf_pkg::rdf_iq12_s got_last // newest pair taken
);
  import rdf_pkg::*;
  logic [1:0] phase_r; // stall pattern position
  // ready moves on the falling edge, well away from sampling
  always_ff @(negedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_r <= 2'h0;
      out_ready <= 1'b1;
    end
    else
    begin
      phase_r <= phase_r + 2'h1;
      out_ready <= !stall_en || (phase_r == 2'h3);
    end
  end
  // record every pair taken at the rising edge
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      got_cnt <= 16'h0;
      got_last <= '0;
    end
    else if (out_valid && out_ready)
    begin
      got_cnt <= got_cnt + 16'h1;
      got_last <= out_data;
    end
  end
endmodule

// >>> testbench/tb_rx_decimation_filter_chain.sv
// self-checking testbench of the receive decimation chain
`timescale 1ns/10ps
module tb_rx_decimation_filter_chain;
  import rdf_pkg::*;
  logic core_clk; // 10 MHz sample clock
  logic rst_b; // async reset, active low
  logic adc_valid; // pair offered
  rdf_iq12_s adc_data; // offered pair
  logic adc_ready; // chain accepts
  logic [1:0] first_mode; // first stage setting
  logic second_en; // second half-band on
  logic third_en; // third half-band on
  logic [1:0] fir_mode; // fir decimation
  logic [1:0] fir_gain; // fir gain code
  logic [2:0] fir_taps_sel; // fir tap groups
  logic fir_clk_div2; // fir at half rate
  logic [6:0] coef_addr; // coefficient index
  logic [7:0] coef_byte; // coefficient byte
  logic coef_wr_lo; // low byte strobe
  logic coef_wr_hi; // high byte strobe
  logic ovf_clear; // status clear
  logic ovf_status_r; // sticky status
  logic ctrl_out_ovf; // overrange pin
  logic out_valid; // output present
  logic out_ready; // sink takes output
  rdf_iq12_s out_data; // output pair
  logic stall_en; // sink stall pattern on
  logic [15:0] got_cnt; // pairs taken by sink
  rdf_iq12_s got_last; // newest pair taken
  logic [15:0] ovf_cnt; // overrange pulses since reset
  int num_errors; // mismatches
  int samples_checked; // comparisons
  rdf_rx_chain DUT (.core_clk(core_clk), .rst_b(rst_b), .adc_valid(adc_valid), .adc_data(adc_data),
    .adc_ready(adc_ready), .first_mode(first_mode), .second_en(second_en), .third_en(third_en),
    .fir_mode(fir_mode), .fir_gain(fir_gain), .fir_taps_sel(fir_taps_sel), .fir_clk_div2(fir_clk_div2),
    .coef_addr(coef_addr), .coef_byte(coef_byte), .coef_wr_lo(coef_wr_lo), .coef_wr_hi(coef_wr_hi),
    .ovf_clear(ovf_clear), .ovf_status_r(ovf_status_r), .ctrl_out_ovf(ctrl_out_ovf),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
  rdf_bb_sink u_sink (.core_clk(core_clk), .rst_b(rst_b), .stall_en(stall_en), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready), .got_cnt(got_cnt), .got_last(got_last));
  // clock generator
  always #50 core_clk = ~core_clk;
  // count overrange pulses on the control pin
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      ovf_cnt <= 16'h0;
    else if (ctrl_out_ovf === 1'b1)
      ovf_cnt <= ovf_cnt + 16'h1;
  end
  // compare one value and report a mismatch
  task chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // verdict and end of run
  task end_of_test;
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // write one coefficient: low byte staged, high byte commits
  task wcoef(input logic [6:0] a, input logic [15:0] v);
    coef_addr = a;
    coef_byte = v[7:0];
    coef_wr_lo = 1'b1;
    @(negedge core_clk);
    coef_wr_lo = 1'b0;
    coef_byte = v[15:8];
    coef_wr_hi = 1'b1;
    @(negedge core_clk);
    coef_wr_hi = 1'b0;
  endtask
  // offer n equal pairs, each held until taken, gap idle cycles between
  task send(input logic [11:0] vi, input logic [11:0] vq, input logic [15:0] n, input logic [1:0] gap);
    int k;
    int t;
    for (k = 0; k < n; k++)
    begin
      adc_valid = 1'b1;
      adc_data.i = vi;
      adc_data.q = vq;
      t = 0;
      while (adc_ready !== 1'b1 && t < 1000)
      begin
        @(negedge core_clk);
        t++;
      end
      @(negedge core_clk);
      if (gap != 2'h0)
      begin
        adc_valid = 1'b0;
        repeat (gap) @(negedge core_clk);
      end
    end
    adc_valid = 1'b0;
  endtask
  // reset with a setting, stream a constant pair, check count and settled output
  // cfg = {first, second, third, fir mode, gain, taps, div2, stall}; ov 16'hffff skips the pulse count
  task run(input logic [12:0] cfg, input logic [1:0] gap, input logic [11:0] xi, input logic [11:0] xq,
    input logic [15:0] n, input logic [11:0] ei, input logic [11:0] eq, input logic [15:0] cnt,
    input logic [15:0] ov);
    int t;
    rst_b = 1'b0;
    {first_mode, second_en, third_en, fir_mode, fir_gain, fir_taps_sel, fir_clk_div2, stall_en} = cfg;
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    @(negedge core_clk);
    chk({14'h0, out_valid, adc_ready}, 16'h1);
    send(xi, xq, n, gap);
    t = 0;
    while (got_cnt !== cnt && t < 4000)
    begin
      @(negedge core_clk);
      t++;
    end
    chk(got_cnt, cnt);
    chk({4'h0, got_last.i}, {4'h0, ei});
    chk({4'h0, got_last.q}, {4'h0, eq});
    if (ov != 16'hffff)
      chk(ovf_cnt, ov);
  endtask
  // cut a hung run short
  initial
  begin
    #(100 * 40000);
    num_errors++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 16'h0, 16'h1);
    end_of_test;
  end
  // main sequence
  initial
  begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    adc_valid = 1'b0;
    adc_data = '0;
    {first_mode, second_en, third_en, fir_mode, fir_gain, fir_taps_sel, fir_clk_div2, stall_en} = 13'h0180;
    coef_addr = 7'h0;
    coef_byte = 8'h0;
    coef_wr_lo = 1'b0;
    coef_wr_hi = 1'b0;
    ovf_clear = 1'b0;
    num_errors = 0;
    samples_checked = 0;
    repeat (20) @(negedge core_clk);
    rst_b = 1'b1;
    @(negedge core_clk);
    // c0 = one half, c17 and c127 = one quarter, the rest zero
    for (int k = 0; k < 128; k++)
      wcoef(7'(k), (k == 0) ? 16'h4000 : ((k == 17 || k == 127) ? 16'h2000 : 16'h0));
    // all bypassed, free and stalled receiver
    run(13'h0180, 2'h0, 12'hb2e, 12'h3ff, 16'h28, 12'hb2e, 12'h3ff, 16'h28, 16'h0);
    run(13'h0181, 2'h0, 12'hb2e, 12'h3ff, 16'h28, 12'hb2e, 12'h3ff, 16'h28, 16'h0);
    // first stage by two and by three, second and third half-bands alone
    run(13'h0980, 2'h0, 12'hd44, 12'h12c, 16'h28, 12'hd44, 12'h12c, 16'h14, 16'h0);
    // by three assumes the configurer also runs the tx interpolator by three
    run(13'h1180, 2'h0, 12'h640, 12'hce0, 16'h30, 12'h5dc, 12'hd12, 16'h10, 16'h0);
    run(13'h0580, 2'h0, 12'h1f4, 12'hf00, 16'h28, 12'h1f4, 12'hf00, 16'h14, 16'h0);
    run(13'h0380, 2'h0, 12'h059, 12'h0b2, 16'h28, 12'h058, 12'h0b0, 16'h14, 16'h0);
    // fir gain codes -12, -6, 0, +6 dB over the fixed +6 dB
    run(13'h0000, 2'h3, 12'h3e8, 12'hda8, 16'h18, 12'h0fa, 12'hf6a, 16'h18, 16'hffff);
    run(13'h0020, 2'h3, 12'h3e8, 12'hda8, 16'h18, 12'h1f4, 12'hed4, 16'h18, 16'h0);
    run(13'h0040, 2'h3, 12'h3e8, 12'hda8, 16'h18, 12'h3e8, 12'hda8, 16'h18, 16'h0);
    run(13'h0060, 2'h3, 12'h3e8, 12'hda8, 16'h18, 12'h7d0, 12'hb50, 16'h18, 16'h0);
    // 32 taps, decimate by four, fir at half clock
    run(13'h0126, 2'h3, 12'h3e8, 12'he70, 16'h40, 12'h2ee, 12'hed4, 16'h10, 16'h0);
    // whole cascade decimating, receiver stalling
    run(13'h0ea1, 2'h0, 12'h059, 12'h0b2, 16'ha0, 12'h02c, 12'h058, 16'h0a, 16'h0);
    // all 128 taps at decimate by two, exactly at the clock-ratio limit
    run(13'h00bc, 2'h3, 12'h3e8, 12'he70, 16'h80, 12'h3e8, 12'he70, 16'h40, 16'hffff);
    // fir overrange clamps both ways and flags every output
    run(13'h0060, 2'h3, 12'h4b0, 12'hbb4, 16'h18, 12'h7ff, 12'h800, 16'h18, 16'h18);
    chk({15'h0, ovf_status_r}, 16'h1);
    ovf_clear = 1'b1;
    @(negedge core_clk);
    ovf_clear = 1'b0;
    @(negedge core_clk);
    chk({15'h0, ovf_status_r}, 16'h0);
    end_of_test;
  end
endmodule
bind rdf_rx_chain rdf_rx_chain_chk u_chk (.core_clk(core_clk), .rst_b(rst_b), .adc_valid(adc_valid),
  .adc_data(adc_data), .adc_ready(adc_ready), .first_mode(first_mode), .second_en(second_en),
  .third_en(third_en), .fir_mode(fir_mode), .ovf_clear(ovf_clear), .ovf_status_r(ovf_status_r),
  .ctrl_out_ovf(ctrl_out_ovf), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
